/* File: logic/clock_channel.sv */
// One generated clock: source select, power-of-two prescaler, low-phase gating
`timescale 1ns/10ps
module clock_channel #(
   parameter logic [2:0] PRE_MAX = clock_reset_pkg::PRE_MAX_LONG,
   parameter logic [1:0] SRC_RST = clock_reset_pkg::SRC_RC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick_pll,
   input wire logic tick_rc,
   input wire logic tick_osc,
   input wire logic tick_slow,
   input wire logic [1:0] src_req,
   input wire logic [2:0] pre_req,
   input wire logic hold_low,
   output logic clk_out,
   output logic [1:0] src_now,
   output logic [2:0] pre_now
);
   typedef struct packed {
      logic out;
      logic [6:0] cnt;
      logic [1:0] src;
      logic [2:0] pre;
   } chan_type;
   chan_type q;
   chan_type next_q;

   function automatic logic [6:0] half_count(input logic [2:0] e);
      half_count = 7'((8'h01 << e) - 8'h01);
   endfunction

   always_comb begin
      logic tick;
      tick = 1'b0;
      next_q = q;
      unique case (q.src)
         clock_reset_pkg::SRC_PLL: tick = tick_pll;
         clock_reset_pkg::SRC_RC: tick = tick_rc;
         clock_reset_pkg::SRC_OSC: tick = tick_osc;
         clock_reset_pkg::SRC_SLOW: tick = tick_slow;
      endcase
      if (tick) begin
         if (q.cnt >= half_count(q.pre)) begin
            next_q.cnt = 7'h00;
            if (q.out) begin
               next_q.out = 1'b0;
            end else if (!hold_low) begin
               next_q.out = 1'b1;
            end
         end else begin
            next_q.cnt = q.cnt + 7'h01;
         end
      end
      // new setting only at low-phase start
      if (!next_q.out && next_q.cnt == 7'h00) begin
         next_q.src = src_req;
         next_q.pre = (pre_req > PRE_MAX) ? PRE_MAX : pre_req;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.src <= SRC_RST;
         q.pre <= clock_reset_pkg::CH_PRE_RST;
      end else begin
         q <= next_q;
      end
   end

   assign clk_out = q.out;
   assign src_now = q.src;
   assign pre_now = q.pre;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_cfg_low;
      $changed(q.pre) || $changed(q.src) |-> !q.out && q.cnt == 7'h00;
   endproperty
   a_cfg_low: assert property (p_cfg_low) else $error("setting changed outside low phase");
   property p_hold;
      hold_low && !q.out |=> !q.out;
   endproperty
   a_hold: assert property (p_hold) else $error("held clock rose");
endmodule

/* File: logic/clock_reset_unit.sv */
// Clock and reset unit: resets, PLL model, generated clocks, APB registers
`timescale 1ns/10ps
module clock_reset_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_reset_pin_low,
   input wire logic watchdog_event,
   input wire logic remap_done,
   input wire logic software_reset_request,
   input wire logic core_sleep,
   input wire logic external_osc_clock,
   input wire logic rc_osc_clock,
   input wire logic slow_crystal_clock,
   input wire logic mii_rx_pad_clock,
   input wire logic mii_tx_pad_clock,
   output logic power_reset_n,
   output logic external_reset_n,
   output logic system_reset_n,
   output logic osc_amp_enable,
   output logic system_core_clock,
   output logic converter_clock,
   output logic serial_port_clock,
   output logic uart_bit_clock,
   output logic timer0_clock,
   output logic timer1_clock,
   output logic [7:0] pwm_channel_clock,
   output logic calendar_clock,
   output logic watchdog_clock,
   output logic random_gen_clock,
   output logic mii_rx_clock,
   output logic mii_tx_clock,
   output logic monitor_clock
);
   localparam int NG = clock_reset_pkg::NUM_GEN;

   typedef struct packed {
      logic [2:0] osc_s, rc_s, slow_s;
      logic [1:0] ext_s, rx_s, tx_s;
      logic [9:0] acc;
      logic pll_tick;
      logic [5:0] pll_m, pll_n;
      logic [1:0] pll_od;
      logic pll_src, pll_byp, osc_amp;
      logic [1:0] gate;
      logic [4:0] mon;
      logic [4:0] cause;
      logic [NG-1:0][1:0] src;
      logic [NG-1:0][2:0] pre;
      logic rx_out, tx_out, mon_out;
      clock_reset_pkg::rst_state_type rst;
      logic [7:0] hold;
      logic sys_req_n;
      logic [31:0] rdata;
      logic ready, slverr;
   } crg_type;
   crg_type q;
   crg_type next_q;

   logic osc_t;
   logic rc_t;
   logic slow_t;
   logic pll_in;
   logic setup;
   logic wr;
   logic sys_arst_n;
   logic ext_arst_n;
   logic [NG-1:0] gen_clk;
   logic [NG-1:0][1:0] src_now;
   logic [NG-1:0][2:0] pre_now;

   function automatic logic addr_hit(input logic [11:0] a);
      addr_hit = (a[1:0] == 2'b00) && (a == clock_reset_pkg::ADDR_CAUSE || a == clock_reset_pkg::ADDR_PLL ||
         a == clock_reset_pkg::ADDR_GATE || a == clock_reset_pkg::ADDR_MON ||
         (a >= clock_reset_pkg::ADDR_CH_BASE && a < clock_reset_pkg::ADDR_CH_END));
   endfunction

   function automatic logic [9:0] pll_div(input logic [5:0] n, input logic [1:0] od);
      logic [9:0] base;
      base = (n == 6'h00) ? 10'h001 : {4'h0, n};
      pll_div = base << od;
   endfunction

   // Edges of the synchronised oscillators; both edges count as ticks
   // primary oscillator, RC and slow crystal sources
   assign osc_t = q.osc_s[1] ^ q.osc_s[2];
   assign rc_t = q.rc_s[1] ^ q.rc_s[2];
   assign slow_t = q.slow_s[1] ^ q.slow_s[2];
   assign pll_in = q.pll_src ? rc_t : osc_t;
   assign setup = psel && !penable;
   assign wr = psel && penable && q.ready && pwrite && addr_hit(paddr);

   always_comb begin
      logic [10:0] sum;
      logic [10:0] div;
      logic [31:0] rd;
      logic [3:0] ch;
      logic [clock_reset_pkg::MON_COUNT-1:0] mon_bus;
      sum = {1'b0, q.acc};
      div = {1'b0, pll_div(q.pll_n, q.pll_od)};
      rd = 32'h0000_0000;
      ch = paddr[5:2];
      mon_bus = {q.tx_out, q.rx_out, gen_clk};
      next_q = q;
      next_q.osc_s = {q.osc_s[1:0], external_osc_clock};
      next_q.rc_s = {q.rc_s[1:0], rc_osc_clock};
      next_q.slow_s = {q.slow_s[1:0], slow_crystal_clock};
      next_q.rx_s = {q.rx_s[0], mii_rx_pad_clock};
      next_q.tx_s = {q.tx_s[0], mii_tx_pad_clock};
      next_q.ext_s = {q.ext_s[0], external_reset_pin_low};

      // PLL rate model: at most one output edge per pclk cycle
      next_q.pll_tick = 1'b0;
      if (q.pll_byp) begin
         next_q.pll_tick = pll_in;
      end else if (pll_in) begin
         sum = sum + {5'h00, q.pll_m};
         if (sum >= div) begin
            next_q.pll_tick = 1'b1;
            sum = sum - div;
            if (sum >= div) begin
               sum = 11'h000;
            end
         end
         next_q.acc = sum[9:0];
      end

      // pad clocks stop only in their low phase
      next_q.rx_out = q.rx_s[1] && (q.gate[clock_reset_pkg::GATE_RX] || q.rx_out);
      next_q.tx_out = q.tx_s[1] && (q.gate[clock_reset_pkg::GATE_TX] || q.tx_out);
      next_q.mon_out = (q.mon < 5'(clock_reset_pkg::MON_COUNT)) ? mon_bus[q.mon] : 1'b0;

      // system reset request stretched to a fixed length
      unique case (q.rst)
         clock_reset_pkg::RST_RUN: begin
            if (watchdog_event || remap_done || software_reset_request) begin
               next_q.rst = clock_reset_pkg::RST_HOLD;
               next_q.hold = clock_reset_pkg::SYS_HOLD_CYCLES - 8'h01;
               next_q.sys_req_n = 1'b0;
            end
         end
         clock_reset_pkg::RST_HOLD: begin
            if (q.hold == 8'h00) begin
               next_q.rst = clock_reset_pkg::RST_RUN;
               next_q.sys_req_n = 1'b1;
            end else begin
               next_q.hold = q.hold - 8'h01;
            end
         end
         default: begin
            next_q.rst = clock_reset_pkg::RST_RUN;
            next_q.sys_req_n = 1'b1;
         end
      endcase

      // Read decode; answer is captured in the setup cycle
      if (paddr == clock_reset_pkg::ADDR_CAUSE) begin
         rd[4:0] = q.cause;
      end else if (paddr == clock_reset_pkg::ADDR_PLL) begin
         rd[clock_reset_pkg::PLL_M_LSB +: 6] = q.pll_m;
         rd[clock_reset_pkg::PLL_N_LSB +: 6] = q.pll_n;
         rd[clock_reset_pkg::PLL_OD_LSB +: 2] = q.pll_od;
         rd[clock_reset_pkg::PLL_SRC_BIT] = q.pll_src;
         rd[clock_reset_pkg::PLL_BYP_BIT] = q.pll_byp;
         rd[clock_reset_pkg::OSC_AMP_BIT] = q.osc_amp;
      end else if (paddr == clock_reset_pkg::ADDR_GATE) begin
         rd[1:0] = q.gate;
      end else if (paddr == clock_reset_pkg::ADDR_MON) begin
         rd[4:0] = q.mon;
      end else if (addr_hit(paddr)) begin
         rd[clock_reset_pkg::CH_SRC_LSB +: 2] = q.src[ch];
         rd[clock_reset_pkg::CH_PRE_LSB +: 3] = q.pre[ch];
         rd[clock_reset_pkg::CH_SRC_NOW_LSB +: 2] = src_now[ch];
         rd[clock_reset_pkg::CH_PRE_NOW_LSB +: 3] = pre_now[ch];
      end
      next_q.ready = setup;
      next_q.slverr = setup && !addr_hit(paddr);
      next_q.rdata = (setup && !pwrite && addr_hit(paddr)) ? rd : 32'h0000_0000;

      if (wr) begin
         if (paddr == clock_reset_pkg::ADDR_CAUSE) begin
            next_q.cause = q.cause & ~pwdata[4:0];
         end else if (paddr == clock_reset_pkg::ADDR_PLL) begin
            next_q.pll_m = pwdata[clock_reset_pkg::PLL_M_LSB +: 6];
            next_q.pll_n = pwdata[clock_reset_pkg::PLL_N_LSB +: 6];
            next_q.pll_od = pwdata[clock_reset_pkg::PLL_OD_LSB +: 2];
            next_q.pll_src = pwdata[clock_reset_pkg::PLL_SRC_BIT];
            next_q.pll_byp = pwdata[clock_reset_pkg::PLL_BYP_BIT];
            // amplifier off for a user-driven clock
            next_q.osc_amp = pwdata[clock_reset_pkg::OSC_AMP_BIT];
         end else if (paddr == clock_reset_pkg::ADDR_GATE) begin
            next_q.gate = pwdata[1:0];
         end else if (paddr == clock_reset_pkg::ADDR_MON) begin
            next_q.mon = pwdata[4:0];
         end else begin
            next_q.src[ch] = pwdata[clock_reset_pkg::CH_SRC_LSB +: 2];
            next_q.pre[ch] = pwdata[clock_reset_pkg::CH_PRE_LSB +: 3];
         end
      end
      // cause flags; a new event beats a clear
      next_q.cause[clock_reset_pkg::CAUSE_EXT] = next_q.cause[clock_reset_pkg::CAUSE_EXT] || !q.ext_s[1];
      next_q.cause[clock_reset_pkg::CAUSE_WDOG] = next_q.cause[clock_reset_pkg::CAUSE_WDOG] || watchdog_event;
      next_q.cause[clock_reset_pkg::CAUSE_REMAP] = next_q.cause[clock_reset_pkg::CAUSE_REMAP] || remap_done;
      next_q.cause[clock_reset_pkg::CAUSE_SW] = next_q.cause[clock_reset_pkg::CAUSE_SW] || software_reset_request;
   end

   // unit state cleared by power reset only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.ext_s <= 2'b11;
         q.pll_m <= clock_reset_pkg::PLL_M_RST;
         q.pll_n <= clock_reset_pkg::PLL_N_RST;
         q.pll_od <= clock_reset_pkg::PLL_OD_RST;
         q.pll_src <= clock_reset_pkg::PLL_SRC_RST;
         q.pll_byp <= clock_reset_pkg::PLL_BYP_RST;
         q.osc_amp <= clock_reset_pkg::OSC_AMP_RST;
         q.gate <= clock_reset_pkg::GATE_RST;
         q.mon <= clock_reset_pkg::MON_RST;
         q.cause <= clock_reset_pkg::CAUSE_RST;
         q.src <= {NG{clock_reset_pkg::SRC_RC}};
         q.src[clock_reset_pkg::CH_RNG] <= clock_reset_pkg::SRC_PLL;
         q.pre <= {NG{clock_reset_pkg::CH_PRE_RST}};
         q.rst <= clock_reset_pkg::RST_RUN;
         q.sys_req_n <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // generated clocks; the random clock is fixed to the PLL
   genvar i;
   generate
      for (i = 0; i < NG; i++) begin : g_ch
         clock_channel #(
            .PRE_MAX((i < 4 || i == clock_reset_pkg::CH_RNG) ? clock_reset_pkg::PRE_MAX_SHORT :
               clock_reset_pkg::PRE_MAX_LONG),
            .SRC_RST((i == clock_reset_pkg::CH_RNG) ? clock_reset_pkg::SRC_PLL : clock_reset_pkg::SRC_RC)
         ) u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .tick_pll(q.pll_tick),
            .tick_rc(rc_t),
            .tick_osc(osc_t),
            .tick_slow(slow_t),
            .src_req(q.src[i]),
            .pre_req(q.pre[i]),
            // sleep holds converter and random clocks
            .hold_low((i == 1 || i == clock_reset_pkg::CH_RNG) ? core_sleep : 1'b0),
            .clk_out(gen_clk[i]),
            .src_now(src_now[i]),
            .pre_now(pre_now[i])
         );
      end
   endgenerate

   assign ext_arst_n = presetn && external_reset_pin_low;
   assign sys_arst_n = ext_arst_n && q.sys_req_n;
   reset_release u_power (.clk(pclk), .arst_n(presetn), .rst_n(power_reset_n));
   reset_release u_ext (.clk(pclk), .arst_n(ext_arst_n), .rst_n(external_reset_n));
   reset_release u_sys (.clk(pclk), .arst_n(sys_arst_n), .rst_n(system_reset_n));

   assign prdata = q.rdata;
   assign pready = q.ready;
   assign pslverr = q.slverr;
   assign osc_amp_enable = q.osc_amp;
   assign system_core_clock = gen_clk[0];
   assign converter_clock = gen_clk[1];
   assign serial_port_clock = gen_clk[2];
   assign uart_bit_clock = gen_clk[3];
   assign timer0_clock = gen_clk[4];
   assign timer1_clock = gen_clk[5];
   assign pwm_channel_clock = gen_clk[13:6];
   assign calendar_clock = gen_clk[14];
   assign watchdog_clock = gen_clk[15];
   assign random_gen_clock = gen_clk[16];
   assign mii_rx_clock = q.rx_out;
   assign mii_tx_clock = q.tx_out;
   assign monitor_clock = q.mon_out;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_sys_hold;
      q.rst == clock_reset_pkg::RST_RUN && (watchdog_event || remap_done || software_reset_request)
         |=> !q.sys_req_n [*8];
   endproperty
   a_sys_hold: assert property (p_sys_hold) else $error("system reset request too short");
   property p_sys_len;
      $fell(q.sys_req_n) |-> ##16 q.sys_req_n;
   endproperty
   a_sys_len: assert property (p_sys_len) else $error("system reset request wrong length");
   property p_sys_out;
      !q.sys_req_n |=> !system_reset_n;
   endproperty
   a_sys_out: assert property (p_sys_out) else $error("system reset not asserted");
   property p_ext_cause;
      !q.ext_s[1] |=> q.cause[clock_reset_pkg::CAUSE_EXT];
   endproperty
   a_ext_cause: assert property (p_ext_cause) else $error("external reset not flagged");
   property p_set_wins;
      wr && paddr == clock_reset_pkg::ADDR_CAUSE && pwdata[clock_reset_pkg::CAUSE_WDOG] && watchdog_event
         |=> q.cause[clock_reset_pkg::CAUSE_WDOG];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("watchdog flag lost to clear");
   property p_sleep;
      core_sleep && !converter_clock && !random_gen_clock |=> !converter_clock && !random_gen_clock;
   endproperty
   a_sleep: assert property (p_sleep) else $error("clock ran in sleep");
   property p_rx_gate;
      !q.gate[clock_reset_pkg::GATE_RX] && !mii_rx_clock |=> !mii_rx_clock;
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("gated receive clock rose");
   property p_bypass;
      q.pll_byp && pll_in |=> q.pll_tick;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass dropped an edge");
   property p_pll_src;
      !q.pll_byp && !pll_in |=> !q.pll_tick;
   endproperty
   a_pll_src: assert property (p_pll_src) else $error("PLL edge without input edge");
   property p_mon;
      q.mon == clock_reset_pkg::MON_RST |=> monitor_clock == $past(gen_clk[0]);
   endproperty
   a_mon: assert property (p_mon) else $error("monitor does not follow system clock");
   property p_unmapped;
      setup && !addr_hit(paddr) |=> pready && pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

   c_sys_reset: cover property ($fell(q.sys_req_n));
   c_ext_flag: cover property ($rose(q.cause[clock_reset_pkg::CAUSE_EXT]));
   c_pll_run: cover property (!q.pll_byp && q.pll_tick);
   c_write: cover property (wr);
endmodule

/* File: logic/reset_release.sv */
// Reset synchroniser: asynchronous assertion, two-flop release
`timescale 1ns/10ps
module reset_release (
   input wire logic clk,
   input wire logic arst_n,
   output logic rst_n
);
   typedef struct packed {
      logic meta;
      logic hold;
   } sync_type;
   sync_type q;
   sync_type next_q;

   always_comb begin
      next_q.meta = 1'b1;
      next_q.hold = q.meta;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign rst_n = q.hold;

   property p_release_late;
      @(posedge clk) disable iff (!arst_n) $rose(rst_n) |-> $past(arst_n) && $past(q.meta);
   endproperty
   a_release_late: assert property (p_release_late) else $error("reset released without two stages");
endmodule

/* File: shared/clock_reset_pkg.sv */
// Constants, field layout and types of the clock and reset unit
package clock_reset_pkg;
   // Register byte addresses
   localparam logic [11:0] ADDR_CAUSE = 12'h000;
   localparam logic [11:0] ADDR_PLL = 12'h004;
   localparam logic [11:0] ADDR_GATE = 12'h008;
   localparam logic [11:0] ADDR_MON = 12'h00C;
   localparam logic [11:0] ADDR_CH_BASE = 12'h040;
   localparam logic [11:0] ADDR_CH_END = 12'h080;
   // Counts
   localparam int NUM_CH = 16;
   localparam int NUM_GEN = 17;
   localparam int CH_RNG = 16;
   localparam int MON_COUNT = 19;
   // Field positions
   localparam int PLL_M_LSB = 0;
   localparam int PLL_N_LSB = 8;
   localparam int PLL_OD_LSB = 16;
   localparam int PLL_SRC_BIT = 20;
   localparam int PLL_BYP_BIT = 24;
   localparam int OSC_AMP_BIT = 28;
   localparam int CH_SRC_LSB = 0;
   localparam int CH_PRE_LSB = 4;
   localparam int CH_SRC_NOW_LSB = 8;
   localparam int CH_PRE_NOW_LSB = 12;
   localparam int CAUSE_POR = 0;
   localparam int CAUSE_EXT = 1;
   localparam int CAUSE_WDOG = 2;
   localparam int CAUSE_REMAP = 3;
   localparam int CAUSE_SW = 4;
   localparam int GATE_RX = 0;
   localparam int GATE_TX = 1;
   typedef enum logic [1:0] {
      SRC_PLL = 2'h0,
      SRC_RC = 2'h1,
      SRC_OSC = 2'h2,
      SRC_SLOW = 2'h3
   } src_type;
   typedef enum logic [1:0] {
      RST_RUN = 2'b01,
      RST_HOLD = 2'b10
   } rst_state_type;
   // Reset values, prescaler limits and system reset hold length
   localparam logic [5:0] PLL_M_RST = 6'h01;
   localparam logic [5:0] PLL_N_RST = 6'h01;
   localparam logic [1:0] PLL_OD_RST = 2'h0;
   localparam logic PLL_SRC_RST = 1'b1;
   localparam logic PLL_BYP_RST = 1'b1;
   localparam logic OSC_AMP_RST = 1'b1;
   localparam logic [1:0] GATE_RST = 2'h3;
   localparam logic [4:0] MON_RST = 5'h00;
   localparam logic [4:0] CAUSE_RST = 5'h01;
   localparam logic [2:0] CH_PRE_RST = 3'h0;
   localparam logic [2:0] PRE_MAX_SHORT = 3'h3;
   localparam logic [2:0] PRE_MAX_LONG = 3'h7;
   localparam logic [7:0] SYS_HOLD_CYCLES = 8'h10;
endpackage

/* File: testbench/clock_reset_unit_tb.sv */
// Self-checking bench: APB register model and clock measurements
`timescale 1ns/10ps
module clock_reset_unit_tb;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, q;
   logic pready, pslverr, e, prev, bad, pin_n = 1'h1, sleep = 1'h0;
   logic [2:0] ev = 3'h0;
   logic rc, osc, slow, rx, tx, pwrr, extr, sysr, amp, conv, rng, mrx, mtx, mon, core;
   logic [3:0] seen;
   logic [31:0] mdl [logic [11:0]];
   int errors = 0, compares = 0, edges = 0, cedges = 0, n, src, pre;
   int exq [$];

   clock_reset_unit dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_reset_pin_low(pin_n),
      .watchdog_event(ev[0]), .remap_done(ev[1]), .software_reset_request(ev[2]), .core_sleep(sleep),
      .external_osc_clock(osc), .rc_osc_clock(rc), .slow_crystal_clock(slow), .mii_rx_pad_clock(rx),
      .mii_tx_pad_clock(tx), .power_reset_n(pwrr), .external_reset_n(extr), .system_reset_n(sysr),
      .osc_amp_enable(amp), .system_core_clock(core), .converter_clock(conv), .serial_port_clock(),
      .uart_bit_clock(), .timer0_clock(), .timer1_clock(), .pwm_channel_clock(), .calendar_clock(),
      .watchdog_clock(), .random_gen_clock(rng), .mii_rx_clock(mrx), .mii_tx_clock(mtx), .monitor_clock(mon)
   );
   pad_clock_source pads (.rc(rc), .osc(osc), .slow(slow), .rx(rx), .tx(tx));

   always #20 pclk = ~pclk;
   always @(posedge mon) edges++;
   always @(posedge core) cedges++;

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         errors++;
         $display("BAD %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   // Edge count of the monitored clock over 320 cycles, one edge of slack for sync jitter
   task automatic freq(input int want);
      repeat (60) @(posedge pclk);
      edges = 0;
      cedges = 0;
      repeat (320) @(posedge pclk);
      chk(32'(edges >= want - 1 && edges <= want + 1), 32'h1);
   endtask

   task automatic watch();
      seen = 4'h0;
      bad = 1'h0;
      repeat (100) begin
         prev = mrx;
         @(posedge pclk);
         seen |= {conv, rng, mrx, mtx};
         bad |= (mon !== prev);
      end
   endtask

   task automatic complete_run();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      errors++;
      complete_run();
   end

   initial begin
      void'($urandom(32'h1273F694));
      mdl[clock_reset_pkg::ADDR_CAUSE] = 32'h00000001;
      mdl[clock_reset_pkg::ADDR_PLL] = 32'h11100101;
      mdl[clock_reset_pkg::ADDR_GATE] = 32'h00000003;
      mdl[clock_reset_pkg::ADDR_MON] = 32'h00000000;
      for (n = 0; n < 16; n++) begin
         mdl[12'h040 + 12'(4 * n)] = 32'h00000101;
      end
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      foreach (mdl[a]) begin
         apb(1'h0, a, 32'h0);
         chk(q, mdl[a]);
      end
      chk(32'({pwrr, extr, sysr, amp}), 32'hF);
      apb(1'h0, 12'h010, 32'h0);
      chk({q[30:0], e}, 32'h1);
      apb(1'h1, 12'h042, 32'hFFFFFFFF);
      chk({q[30:0], e}, 32'h1);
      // Random source and prescale per channel; fast group saturates at 3
      for (n = 0; n < 16; n++) begin
         src = $urandom % 4;
         pre = $urandom % 8;
         apb(1'h1, 12'h040 + 12'(4 * n), 32'(src + 16 * pre));
         exq.push_back(src * 257 + 4096 * ((n < 4 && pre > 3) ? 3 : pre));
      end
      repeat (60) @(posedge pclk);
      for (n = 0; n < 16; n++) begin
         apb(1'h0, 12'h040 + 12'(4 * n), 32'h0);
         chk(q & 32'h00007303, 32'(exq.pop_front()));
      end
      apb(1'h1, 12'h040, 32'h1);
      apb(1'h1, 12'h044, 32'h1);
      apb(1'h1, 12'h078, 32'h3);
      apb(1'h1, clock_reset_pkg::ADDR_MON, 32'hE);
      // Slowest old setting may need a whole low and high phase before it yields
      repeat (6500) @(posedge pclk);
      freq(6);
      apb(1'h1, clock_reset_pkg::ADDR_MON, 32'h0);
      for (n = 0; n < 5; n++) begin
         apb(1'h1, 12'h040, 32'(1 + 16 * n));
         freq(32 >> ((n > 3) ? 3 : n));
         chk(32'(cedges >= edges - 1 && cedges <= edges + 1), 32'h1);
      end
      apb(1'h1, clock_reset_pkg::ADDR_MON, 32'h10);
      freq(32);
      for (n = 0; n < 4; n++) begin
         apb(1'h1, clock_reset_pkg::ADDR_PLL, 32'h00100202 + 32'(n << 16));
         freq(32 >> n);
      end
      apb(1'h1, clock_reset_pkg::ADDR_PLL, 32'h00000202);
      freq(23);
      chk(32'(amp), 32'h0);
      apb(1'h1, clock_reset_pkg::ADDR_MON, 32'h11);
      apb(1'h1, clock_reset_pkg::ADDR_GATE, 32'h0);
      sleep <= 1'h1;
      repeat (30) @(posedge pclk);
      watch();
      chk(32'(seen), 32'h0);
      apb(1'h1, clock_reset_pkg::ADDR_GATE, 32'h3);
      sleep <= 1'h0;
      repeat (30) @(posedge pclk);
      watch();
      chk(32'({seen, bad}), 32'h1E);
      for (n = 0; n < 3; n++) begin
         ev <= 3'(1 << n);
         @(posedge pclk);
         ev <= 3'h0;
         src = 0;
         repeat (30) begin
            @(posedge pclk);
            src += 32'(!sysr);
         end
         chk(32'(src > 14 && src < 21 && extr && pwrr), 32'h1);
      end
      apb(1'h0, clock_reset_pkg::ADDR_CAUSE, 32'h0);
      chk(q, 32'h1D);
      apb(1'h0, clock_reset_pkg::ADDR_MON, 32'h0);
      chk(q, 32'h11);
      // Watchdog event lands on the clearing write: the set must win
      fork
         apb(1'h1, clock_reset_pkg::ADDR_CAUSE, 32'h1F);
         begin
            @(posedge pclk);
            ev <= 3'h1;
            @(posedge pclk);
            ev <= 3'h0;
         end
      join
      pin_n <= 1'h0;
      #5;
      chk(32'({extr, sysr, pwrr}), 32'h1);
      repeat (3) @(posedge pclk);
      pin_n <= 1'h1;
      repeat (5) @(posedge pclk);
      apb(1'h0, clock_reset_pkg::ADDR_CAUSE, 32'h0);
      chk(q, 32'h6);
      apb(1'h0, clock_reset_pkg::ADDR_MON, 32'h0);
      chk(q, 32'h11);
      presetn <= 1'h0;
      #5;
      chk(32'({extr, sysr, pwrr}), 32'h0);
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, clock_reset_pkg::ADDR_MON, 32'h0);
      chk(q, 32'h0);
      complete_run();
   end
endmodule

/* File: testbench/pad_clock_source.sv */
// Free-running oscillator and pad clock sources around the unit
`timescale 1ns/10ps
module pad_clock_source (
   output logic rc,
   output logic osc,
   output logic slow,
   output logic rx,
   output logic tx
);
   // Rates kept far below pclk/2 so the sync flops see every edge
   initial begin
      {rc, osc, slow, rx, tx} = 5'h00;
   end
   always #200 rc = ~rc;
   always #280 osc = ~osc;
   always #1000 slow = ~slow;
   always #330 rx = ~rx;
   always #370 tx = ~tx;
endmodule
